// File: src/cpmlm_params.svh
`ifndef CPMLM_PARAMS_SVH
`define CPMLM_PARAMS_SVH
// Register byte offsets
`define CPMLM_ADDR_CTRL     12'h000
`define CPMLM_ADDR_LINE     12'h004
`define CPMLM_ADDR_STATUS   12'h008
`define CPMLM_ADDR_VIOL     12'h00C
`define CPMLM_ADDR_FRAC_OH  12'h010
// Control register fields
`define CPMLM_CTRL_FM_LSB   0
`define CPMLM_CTRL_FM_MSB   5
`define CPMLM_CTRL_ALIGN    8
`define CPMLM_CTRL_PKT      9
`define CPMLM_CTRL_CBIT_PL  10
`define CPMLM_CTRL_PLB      11
// Line register fields
`define CPMLM_LINE_LM_LSB   0
`define CPMLM_LINE_LM_MSB   2
`define CPMLM_LINE_TX_ZERO_SUPPRESS_DISABLE     4
`define CPMLM_LINE_RX_ZERO_SUPPRESS_DISABLE     5
`define CPMLM_LINE_ALB      6
// Fractional overhead pattern select field
`define CPMLM_FOH_LSB       0
`define CPMLM_FOH_MSB       1
// Reset values
`define CPMLM_CTRL_RST      32'h0000_0000
`define CPMLM_LINE_RST      32'h0000_0000
`define CPMLM_FOH_RST       2'h0
`define CPMLM_VIOL_RST      16'h0000
`define CPMLM_VIOL_MAX      16'hFFFF
// Framing mode code groups
`define CPMLM_FM_CLEAR      1'b1
`define CPMLM_FAM_DS3_CBIT  2'h0
`define CPMLM_FAM_DS3_M23   2'h1
`define CPMLM_FAM_E3_G751   2'h2
`define CPMLM_FAM_E3_G832   2'h3
`define CPMLM_SUB_DIRECT    3'h0
`define CPMLM_SUB_OHM       3'h1
`define CPMLM_SUB_IFRAC     3'h2
`define CPMLM_SUB_OHM_OCT   3'h3
`define CPMLM_SUB_PLCP      3'h4
`define CPMLM_SUB_PLCP_OHM  3'h5
`define CPMLM_SUB_RSVD      3'h7
`define CPMLM_SUB_PLCP_GRP  2'h2
// E3 PLCP forced leading payload nibble
`define CPMLM_E3_PLCP_LEAD  4'hC
// Fractional overhead patterns
`define CPMLM_FOH_ONES      4'hF
`define CPMLM_FOH_ZEROS     4'h0
`define CPMLM_FOH_ALT       4'hA
`endif

// File: src/cpmlm_pkg.sv
package cpmlm_pkg;
  typedef enum logic [1:0] {
    CPMLM_AL_BIT,
    CPMLM_AL_NIBBLE,
    CPMLM_AL_BYTE,
    CPMLM_AL_CELL
  } cpmlm_align_type;

  typedef enum logic [1:0] {
    CPMLM_CODE_B3ZS,
    CPMLM_CODE_HDB3,
    CPMLM_CODE_AMI,
    CPMLM_CODE_UNI
  } cpmlm_code_type;

  typedef enum logic [1:0] {
    CPMLM_JA_OFF,
    CPMLM_JA_TX,
    CPMLM_JA_RX
  } cpmlm_ja_type;

  typedef struct packed {
    cpmlm_align_type cell_align;
    cpmlm_align_type pkt_align;
    logic            cell_search_byte;
    logic            pkt_octet_stuff;
    logic            plcp_search_byte;
    logic            plcp_en;
    logic            cfg_error;
  } cpmlm_map_type;

  typedef struct packed {
    cpmlm_code_type code;
    logic           liu_en;
    cpmlm_ja_type   ja;
    logic           digital_loop;
  } cpmlm_line_type;

  typedef struct packed {
    logic clk;
    logic pos;
    logic neg;
  } cpmlm_rails_type;
endpackage

// File: src/cpmlm_top.sv
// Functional notes
// R1: Cell search bitwise, bytewise in octet mask modes
// R2: Packets bit stuffed, octet stuffed in octet modes
// R3: PLCP alignment always searched bit by bit
// R4: DS3 direct: cells per select, packets bit
// R5: DS3 PLCP nibble aligned, select ignored
// R6: Cells cell-aligned in PLCP, no packets
// R7: DS3 PLCP only in C-bit generated frames; code accepts M23 PLCP too
// R8: Software sets bit align for payload C-bits
// R9: Software avoids PLCP with payload C-bits
// R10: G.751 direct: cells and packets bit aligned
// R11: E3 PLCP forces 1100, then byte aligned
// R12: E3 PLCP only within G.751 frames
// R13: Software sets fractional section and group size
// R14: G.751 fractional overhead pattern, bit aligned
// R15: G.832: cells per select, packets bit
// R16: Unipolar: no coding, count external pulses
// R17: Mask modes never count violation pin pulses
// R18: Loopback without line unit returns rails digitally
// R19: DS3/52M use B3ZS, E3 uses HDB3
// R20: Line mode field decodes unit and attenuator
// R21: Both suppress disables select AMI coding
// R22: Mask modes: mask pins, no payload loopback
// R23: Alignment select per port, one means bit
`timescale 1ns/1ns
`include "cpmlm_params.svh"
module cpmlm_top (
  // Clock, reset, enable
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     clk_en,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Transmit rails from encoder and receive rails from line unit
  input  wire cpmlm_pkg::cpmlm_rails_type tx_rails,
  input  wire cpmlm_pkg::cpmlm_rails_type rx_line_rails,
  input  wire logic                     rx_neg_violation_mask_pin,
  // Decoded configuration
  output cpmlm_pkg::cpmlm_map_type      map_cfg_ff,
  output cpmlm_pkg::cpmlm_line_type     line_cfg_ff,
  output logic                          overhead_mask_mode_ff,
  output logic                          payload_loopback_ff,
  output logic [3:0]                    lead_bits_ff,
  output logic                          lead_force_ff,
  // Receive rails toward decoder
  output cpmlm_pkg::cpmlm_rails_type    rx_rails_ff
);

  logic [31:0] ctrl_ff;
  logic [31:0] line_ff;
  logic [1:0]  foh_sel_ff;
  logic [15:0] viol_cnt_ff;
  logic        pin_d_ff;
  logic [31:0] nxt_prdata;
  logic        nxt_pslverr;
  logic        wr_access;
  logic        setup_cyc;
  logic        pin_rise;
  logic        count_en;
  logic [5:0]  fm;
  logic [2:0]  lm;
  logic        align_bit;
  logic        is_pkt;
  logic        cbit_payload;
  cpmlm_pkg::cpmlm_map_type  nxt_map;
  cpmlm_pkg::cpmlm_line_type nxt_line;
  logic        nxt_ohm;
  logic [3:0]  nxt_lead;
  logic        nxt_force;

  function automatic logic is_ohm(input logic [5:0] f);
    logic [2:0] s;
    s = f[2:0];
    if (f[5] == `CPMLM_FM_CLEAR)
      is_ohm = (s == `CPMLM_SUB_OHM) || (s == `CPMLM_SUB_OHM_OCT);
    else
      is_ohm = (s == `CPMLM_SUB_OHM) || (s == `CPMLM_SUB_PLCP_OHM);
  endfunction

  function automatic logic is_octet_ohm(input logic [5:0] f);
    is_octet_ohm = (f[5] == `CPMLM_FM_CLEAR) && (f[2:0] == `CPMLM_SUB_OHM_OCT);
  endfunction

  function automatic logic is_e3(input logic [5:0] f);
    is_e3 = f[4];
  endfunction

  function automatic logic is_plcp(input logic [5:0] f);
    is_plcp = (f[5] != `CPMLM_FM_CLEAR) && (f[2:1] == `CPMLM_SUB_PLCP_GRP);
  endfunction

  assign fm           = ctrl_ff[`CPMLM_CTRL_FM_MSB:`CPMLM_CTRL_FM_LSB];
  assign lm           = line_ff[`CPMLM_LINE_LM_MSB:`CPMLM_LINE_LM_LSB];
  assign align_bit    = ctrl_ff[`CPMLM_CTRL_ALIGN];
  assign is_pkt       = ctrl_ff[`CPMLM_CTRL_PKT];
  assign cbit_payload = ctrl_ff[`CPMLM_CTRL_CBIT_PL];

  assign wr_access = psel && penable && pwrite;
  assign setup_cyc = psel && !penable;

  // Control register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `CPMLM_CTRL_RST;
    end else if (clk_en && wr_access && paddr == `CPMLM_ADDR_CTRL) begin
      ctrl_ff <= pwdata; // R23
    end
  end

  // Line register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_ff <= `CPMLM_LINE_RST;
    end else if (clk_en && wr_access && paddr == `CPMLM_ADDR_LINE) begin
      line_ff <= pwdata;
    end
  end

  // Fractional overhead pattern select write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      foh_sel_ff <= `CPMLM_FOH_RST;
    end else if (clk_en && wr_access && paddr == `CPMLM_ADDR_FRAC_OH) begin
      foh_sel_ff <= pwdata[`CPMLM_FOH_MSB:`CPMLM_FOH_LSB]; // R14
    end
  end

  // Read data and error answer
  always_comb begin
    nxt_prdata  = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    unique case (paddr)
      `CPMLM_ADDR_CTRL:    nxt_prdata = ctrl_ff;
      `CPMLM_ADDR_LINE:    nxt_prdata = line_ff;
      `CPMLM_ADDR_STATUS:  nxt_prdata = {17'h0_0000, map_cfg_ff, line_cfg_ff};
      `CPMLM_ADDR_VIOL:    nxt_prdata = {16'h0000, viol_cnt_ff};
      `CPMLM_ADDR_FRAC_OH: nxt_prdata = {30'h0000_0000, foh_sel_ff};
      default:             nxt_pslverr = 1'b1;
    endcase
  end

  // Ready in the access cycle after each setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (clk_en) begin
      pready <= setup_cyc;
    end
  end

  // Error answer for unmapped addresses, alongside ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pslverr <= setup_cyc && nxt_pslverr;
    end
  end

  // Read data taken at setup, held until the next setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && setup_cyc) begin
      prdata <= nxt_prdata;
    end
  end

  // Mapping decode
  always_comb begin
    nxt_map                  = '0;
    nxt_map.cell_search_byte = is_octet_ohm(fm); // R1
    nxt_map.pkt_octet_stuff  = is_octet_ohm(fm); // R2
    nxt_map.plcp_search_byte = 1'b0; // R3
    nxt_map.cell_align       = cpmlm_pkg::CPMLM_AL_BIT;
    nxt_map.pkt_align        = cpmlm_pkg::CPMLM_AL_BIT;
    nxt_lead                 = 4'h0;
    nxt_force                = 1'b0;
    if (fm[5] == `CPMLM_FM_CLEAR) begin
      nxt_map.cfg_error = fm[2];
      if (is_octet_ohm(fm)) begin
        nxt_map.cell_align = cpmlm_pkg::CPMLM_AL_BYTE; // R1
        nxt_map.pkt_align  = cpmlm_pkg::CPMLM_AL_BYTE; // R2
      end
    end else if (is_plcp(fm)) begin
      // PLCP modes
      nxt_map.plcp_en    = 1'b1;
      nxt_map.cell_align = cpmlm_pkg::CPMLM_AL_CELL; // R5 R6
      nxt_map.pkt_align  = cpmlm_pkg::CPMLM_AL_BIT;
      nxt_map.cfg_error  = is_pkt; // R6
      unique case (fm[4:3])
        `CPMLM_FAM_DS3_CBIT, `CPMLM_FAM_DS3_M23: begin
          nxt_map.cfg_error = is_pkt || cbit_payload; // R7
        end
        `CPMLM_FAM_E3_G751: begin
          nxt_lead  = `CPMLM_E3_PLCP_LEAD; // R11
          nxt_force = 1'b1; // R11
        end
        `CPMLM_FAM_E3_G832: begin
          nxt_map.plcp_en   = 1'b0;
          nxt_map.cfg_error = 1'b1; // R12
        end
      endcase
    end else begin
      nxt_map.cfg_error = (fm[2:0] == `CPMLM_SUB_RSVD);
      unique case (fm[4:3])
        `CPMLM_FAM_DS3_CBIT, `CPMLM_FAM_DS3_M23: begin
          if (!align_bit && !(fm[3] && cbit_payload)) // R8
            nxt_map.cell_align = cpmlm_pkg::CPMLM_AL_NIBBLE; // R4
        end
        `CPMLM_FAM_E3_G751: begin // R10
          if (fm[2:0] == `CPMLM_SUB_IFRAC) begin
            nxt_force = 1'b1; // R14
            unique case (foh_sel_ff)
              2'h0:    nxt_lead = `CPMLM_FOH_ONES; // R14
              2'h1:    nxt_lead = `CPMLM_FOH_ZEROS; // R14
              default: nxt_lead = `CPMLM_FOH_ALT; // R14
            endcase
          end
        end
        `CPMLM_FAM_E3_G832: begin
          if (!align_bit)
            nxt_map.cell_align = cpmlm_pkg::CPMLM_AL_BYTE; // R15
        end
      endcase
    end
  end

  // Line mode decode
  always_comb begin
    nxt_line              = '0;
    nxt_line.digital_loop = 1'b0;
    if (lm[2]) begin
      nxt_line.code = cpmlm_pkg::CPMLM_CODE_UNI; // R20
    end else begin
      if (line_ff[`CPMLM_LINE_TX_ZERO_SUPPRESS_DISABLE] && line_ff[`CPMLM_LINE_RX_ZERO_SUPPRESS_DISABLE])
        nxt_line.code = cpmlm_pkg::CPMLM_CODE_AMI; // R21
      else if (is_e3(fm))
        nxt_line.code = cpmlm_pkg::CPMLM_CODE_HDB3; // R19
      else
        nxt_line.code = cpmlm_pkg::CPMLM_CODE_B3ZS; // R19
      nxt_line.liu_en = (lm[1:0] != 2'h0); // R20
      unique case (lm[1:0])
        2'h2:    nxt_line.ja = cpmlm_pkg::CPMLM_JA_TX; // R20
        2'h3:    nxt_line.ja = cpmlm_pkg::CPMLM_JA_RX; // R20
        default: nxt_line.ja = cpmlm_pkg::CPMLM_JA_OFF;
      endcase
    end
    nxt_line.digital_loop = line_ff[`CPMLM_LINE_ALB] && !nxt_line.liu_en; // R18
  end

  assign nxt_ohm = is_ohm(fm);

  // Registered mapping configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_cfg_ff <= '0;
    end else if (clk_en) begin
      map_cfg_ff <= nxt_map;
    end
  end

  // Registered line configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_cfg_ff <= '0;
    end else if (clk_en) begin
      line_cfg_ff <= nxt_line;
    end
  end

  // Overhead mask mode flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overhead_mask_mode_ff <= 1'b0;
    end else if (clk_en) begin
      overhead_mask_mode_ff <= nxt_ohm; // R22
    end
  end

  // Payload loopback, blocked in mask modes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      payload_loopback_ff <= 1'b0;
    end else if (clk_en) begin
      payload_loopback_ff <= ctrl_ff[`CPMLM_CTRL_PLB] && !nxt_ohm; // R22
    end
  end

  // Forced leading payload bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lead_bits_ff <= 4'h0;
    end else if (clk_en) begin
      lead_bits_ff <= nxt_lead;
    end
  end

  // Leading bit force enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lead_force_ff <= 1'b0;
    end else if (clk_en) begin
      lead_force_ff <= nxt_force;
    end
  end

  // Receive rail select with digital loopback
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rx_rails_ff <= '0;
    else if (clk_en)
      rx_rails_ff <= line_cfg_ff.digital_loop ? tx_rails : rx_line_rails; // R18
  end

  assign pin_rise = rx_neg_violation_mask_pin && !pin_d_ff;
  assign count_en = (line_cfg_ff.code == cpmlm_pkg::CPMLM_CODE_UNI) // R16
                    && !overhead_mask_mode_ff; // R17

  // Edge register for the shared violation pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_d_ff <= 1'b0;
    end else if (clk_en) begin
      pin_d_ff <= rx_neg_violation_mask_pin;
    end
  end

  // Violation pulse counter, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      viol_cnt_ff <= `CPMLM_VIOL_RST;
    end else if (clk_en && count_en && pin_rise && viol_cnt_ff != `CPMLM_VIOL_MAX) begin
      viol_cnt_ff <= viol_cnt_ff + 16'h0001; // R16
    end
  end

endmodule

// File: tb/cpmlm_line_model.sv
`timescale 1ns/1ns
module cpmlm_line_model (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // Rails and violation pin
  output cpmlm_pkg::cpmlm_rails_type tx_rails,
  output cpmlm_pkg::cpmlm_rails_type rx_line_rails,
  output logic                       rx_neg_violation_mask_pin
);
  logic       hold;
  logic [2:0] cnt_ff;
  initial begin
    hold = 1'b0;
    rx_neg_violation_mask_pin = 1'b0;
  end
  // Rails change every cycle unless held; line side is the inverse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 3'h0;
    end else if (!hold) begin
      cnt_ff <= cnt_ff + 3'h1;
    end
  end
  assign tx_rails      = cnt_ff;
  assign rx_line_rails = ~cnt_ff;
  // External pulses on the shared pin
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge pclk);
      rx_neg_violation_mask_pin <= 1'b1;
      repeat (2) @(posedge pclk);
      rx_neg_violation_mask_pin <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask
endmodule

// File: tb/cpmlm_asserts.sv
`timescale 1ns/1ns
module cpmlm_asserts (
  // Clock and bus
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       clk_en,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pready,
  input wire logic                       pslverr,
  // Rails
  input wire cpmlm_pkg::cpmlm_rails_type tx_rails,
  input wire cpmlm_pkg::cpmlm_rails_type rx_line_rails,
  input wire cpmlm_pkg::cpmlm_rails_type rx_rails_ff,
  // Decoded configuration
  input wire cpmlm_pkg::cpmlm_map_type   map_cfg_ff,
  input wire cpmlm_pkg::cpmlm_line_type  line_cfg_ff,
  input wire logic                       overhead_mask_mode_ff,
  input wire logic                       payload_loopback_ff,
  input wire logic [3:0]                 lead_bits_ff,
  input wire logic                       lead_force_ff
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_setup_ready: assert property (psel && !penable && clk_en |=> pready && !$past(pready))
    else $error("no ready after setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_uni_off: assert property (
    line_cfg_ff.code == cpmlm_pkg::CPMLM_CODE_UNI |-> !line_cfg_ff.liu_en && line_cfg_ff.ja == 0)
    else $error("unipolar with unit on");
  a_ja_unit: assert property (line_cfg_ff.ja != 0 |-> line_cfg_ff.liu_en)
    else $error("attenuator without unit");
  a_mask_no_plb: assert property (overhead_mask_mode_ff |-> !payload_loopback_ff)
    else $error("payload loop in mask mode");
  a_plcp_bitwise: assert property (!map_cfg_ff.plcp_search_byte)
    else $error("plcp byte search");
  a_byte_mask: assert property (
    map_cfg_ff.cell_search_byte || map_cfg_ff.pkt_octet_stuff |-> overhead_mask_mode_ff)
    else $error("byte search outside mask mode");
  a_lead_bits: assert property (
    lead_force_ff && map_cfg_ff.plcp_en |-> lead_bits_ff == 4'hC)
    else $error("lead bits wrong");
  a_frac_lead: assert property (
    lead_force_ff && !map_cfg_ff.plcp_en |-> lead_bits_ff inside {4'hF, 4'h0, 4'hA})
    else $error("fractional overhead pattern wrong");
  a_plcp_cell: assert property (map_cfg_ff.plcp_en |-> map_cfg_ff.cell_align == 2'h3)
    else $error("plcp cell not cell aligned");
  a_loop_rails: assert property (
    clk_en && line_cfg_ff.digital_loop |=> rx_rails_ff == $past(tx_rails))
    else $error("loop rails wrong");
  a_line_rails: assert property (
    clk_en && !line_cfg_ff.digital_loop |=> rx_rails_ff == $past(rx_line_rails))
    else $error("line rails wrong");
endmodule
bind cpmlm_top cpmlm_asserts chk_u (.*);

// File: tb/tb_cell_packet_mapping_line_mode.sv
`timescale 1ns/1ns
module tb_cell_packet_mapping_line_mode;
  logic                       pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [11:0]                paddr;
  logic [31:0]                pwdata, prdata, q;
  logic                       e, rx_neg_violation_mask_pin, overhead_mask_mode_ff;
  logic                       payload_loopback_ff, lead_force_ff;
  logic [3:0]                 lead_bits_ff;
  logic [8:0]                 got;
  logic [15:0]                v0;
  cpmlm_pkg::cpmlm_rails_type tx_rails, rx_line_rails, rx_rails_ff;
  cpmlm_pkg::cpmlm_map_type   map_cfg_ff;
  cpmlm_pkg::cpmlm_line_type  line_cfg_ff;
  int                         n_mismatch = 0;
  int                         checks_done = 0;
  int                         cyc = 0;
  // Control, line, expected {cell, packet, code, unit, attenuator}
  logic [28:0] rows [0:10] = '{{12'h000, 8'h00, 9'h080}, {12'h100, 8'h01, 9'h004},
    {12'h010, 8'h02, 9'h00D}, {12'h018, 8'h03, 9'h10E}, {12'h318, 8'h33, 9'h016},
    {12'h012, 8'h04, 9'h018}, {12'h104, 8'h10, 9'h180}, {12'h014, 8'h05, 9'h198},
    {12'h310, 8'h32, 9'h015}, {12'h008, 8'h00, 9'h080}, {12'h508, 8'h00, 9'h000}};
  cpmlm_top dut_u (.*);
  cpmlm_line_model line_u (.*);
  always #4 pclk = ~pclk;
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic cfg(input logic [11:0] c, input logic [7:0] l);
    apb(1'b1, 12'h000, {20'h0, c});
    apb(1'b1, 12'h004, {24'h0, l});
    repeat (2) @(posedge pclk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    {pclk, presetn, clk_en, psel, penable, pwrite} = 6'h08;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (16) @(posedge pclk);
    chk("map_rst", 32'h0, 32'(map_cfg_ff));
    chk("line_rst", 32'h0, 32'(line_cfg_ff));
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      cfg(rows[i][28:17], rows[i][16:9]);
      got = {map_cfg_ff.cell_align, map_cfg_ff.pkt_align, line_cfg_ff.code,
             line_cfg_ff.liu_en, line_cfg_ff.ja};
      if (rows[i][8:7] == 2'h3) got[6:5] = 2'h0;
      chk("decode", 32'(rows[i][8:0]), 32'(got));
    end
    cfg(12'h014, 8'h00);
    chk("lead", 32'h1C, {27'h0, lead_force_ff, lead_bits_ff});
    apb(1'b1, 12'h010, 32'h2);
    cfg(12'h012, 8'h00);
    chk("frac_lead", 32'h1A, {27'h0, lead_force_ff, lead_bits_ff});
    cfg(12'h40C, 8'h00);
    chk("m23_plcp_err", 32'h1, 32'(map_cfg_ff.cfg_error));
    cfg(12'h01C, 8'h00);
    chk("g832_plcp_err", 32'h1, 32'(map_cfg_ff.cfg_error));
    cfg(12'h223, 8'h04);
    chk("octet", 32'h7, {29'h0, overhead_mask_mode_ff, map_cfg_ff.cell_search_byte,
        map_cfg_ff.pkt_octet_stuff});
    cfg(12'h221, 8'h04);
    chk("bitwise", 32'h4, {29'h0, overhead_mask_mode_ff, map_cfg_ff.cell_search_byte,
        map_cfg_ff.pkt_octet_stuff});
    cfg(12'h801, 8'h04);
    chk("plb_mask", 32'h2, {30'h0, overhead_mask_mode_ff, payload_loopback_ff});
    cfg(12'h800, 8'h04);
    chk("plb", 32'h1, {30'h0, overhead_mask_mode_ff, payload_loopback_ff});
    apb(1'b0, 12'h00C, 32'h0);
    v0 = q[15:0];
    line_u.pulse(5);
    apb(1'b0, 12'h00C, 32'h0);
    chk("viol_uni", 32'(v0 + 16'h5), {16'h0, q[15:0]});
    v0 = q[15:0];
    clk_en <= 1'b0;
    line_u.pulse(2);
    clk_en <= 1'b1;
    apb(1'b0, 12'h00C, 32'h0);
    chk("viol_frozen", 32'(v0), {16'h0, q[15:0]});
    cfg(12'h001, 8'h04);
    apb(1'b0, 12'h00C, 32'h0);
    v0 = q[15:0];
    line_u.pulse(3);
    apb(1'b0, 12'h00C, 32'h0);
    chk("viol_mask", 32'(v0), {16'h0, q[15:0]});
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, q);
    presetn <= 1'b0;
    @(posedge pclk);
    chk("map_rst2", 32'h0, 32'(map_cfg_ff));
    chk("line_rst2", 32'h0, 32'(line_cfg_ff));
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl_rst2", 32'h0, q);
    cfg(12'h000, 8'h40);
    line_u.hold <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("loop_rails", 32'(tx_rails), 32'(rx_rails_ff));
    line_u.hold <= 1'b0;
    cfg(12'h000, 8'h41);
    line_u.hold <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("line_rails", 32'(rx_line_rails), 32'(rx_rails_ff));
    conclude();
  end
endmodule
